// ==== hw/gst_pkg.sv ====
// Purpose: Shared constants and types of the gated sixteen bit timer.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Control fields follow the control byte layout, bit 7 down to bit 0.
package gst_pkg;

  localparam logic [7:0] GST_OFF_COUNT_LOW  = 8'h00;
  localparam logic [7:0] GST_OFF_COUNT_HIGH = 8'h04;
  localparam logic [7:0] GST_OFF_CONTROL    = 8'h08;
  localparam logic [7:0] GST_OFF_IRQ_CFG    = 8'h0c;
  localparam logic [7:0] GST_OFF_STATUS     = 8'h10;
  localparam logic [7:0] GST_OFF_PORT       = 8'h14;

  localparam logic [7:0] GST_CONTROL_RESET  = 8'h00;
  localparam logic [3:0] GST_IRQ_CFG_RESET  = 4'h0;
  localparam logic [1:0] GST_PORT_DIR_RESET = 2'h3;

  localparam int GST_IRQ_GSS_BIT  = 0;
  localparam int GST_IRQ_IE_BIT   = 1;
  localparam int GST_IRQ_PERIPHERAL_IRQ_ENABLE_BIT = 2;
  localparam int GST_IRQ_GIE_BIT  = 3;
  localparam int GST_STATUS_OVF_BIT = 0;

  localparam logic [1:0] GST_INSTR_DIV_LAST = 2'h3;
  localparam logic [15:0] GST_COUNT_ALL_ONES = 16'hffff;

  typedef enum logic [1:0] {
    GST_DIV1 = 2'b00,
    GST_DIV2 = 2'b01,
    GST_DIV4 = 2'b10,
    GST_DIV8 = 2'b11
  } gst_prescale_e;

  typedef struct packed {
    logic          gate_polarity;
    logic          gate_enable;
    gst_prescale_e prescale_select;
    logic          crystal_osc_enable;
    logic          sync_bypass;
    logic          clock_source_select;
    logic          timer_on;
  } gst_ctrl_s;

endpackage : gst_pkg

// ==== hw/gst_edge_detect.sv ====
// Purpose: Rising and falling edge detection of the external count input.
// Assumes: Input is sampled on pclk.
// Notes:   Sync path uses two stages; bypass path uses a single sample.
`timescale 1ns/1ps
module gst_edge_detect (
  input  wire logic pclk,      // System clock.
  input  wire logic presetn,   // Asynchronous reset, active low.
  input  wire logic bypass,    // Skip the synchroniser.
  input  wire logic din,       // Raw external count input.
  output logic      rise,      // One-cycle rising edge pulse.
  output logic      fall       // One-cycle falling edge pulse.
);
  logic sync_a;
  logic sync_b;
  logic sync_prev;
  logic raw_q;
  logic raw_prev;
  wire  cur  = bypass ? raw_q : sync_b;
  wire  prev = bypass ? raw_prev : sync_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a    <= 1'b0;
      sync_b    <= 1'b0;
      sync_prev <= 1'b0;
      raw_q     <= 1'b0;
      raw_prev  <= 1'b0;
    end else begin
      sync_a    <= din;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
      raw_q     <= din;
      raw_prev  <= raw_q;
    end
  end

  assign rise = cur & ~prev;
  assign fall = ~cur & prev;
endmodule : gst_edge_detect

// ==== hw/gst_prescaler.sv ====
// Purpose: Divide count ticks by 1, 2, 4 or 8.
// Assumes: tick is a one-cycle pulse.
// Notes:   The counter is not visible to software.
`timescale 1ns/1ps
module gst_prescaler #(
  parameter int WIDTH = 3
) (
  input  wire logic                  pclk,    // System clock.
  input  wire logic                  presetn, // Asynchronous reset, active low.
  input  wire logic                  clear,   // Clear the prescale counter.
  input  wire logic                  tick,    // Input tick pulse.
  input  wire gst_pkg::gst_prescale_e sel,    // Division select.
  output logic                       inc      // Increment pulse.
);
  import gst_pkg::*;
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] mask;

  always_comb begin
    unique case (sel)
      GST_DIV1: mask = WIDTH'(0);
      GST_DIV2: mask = WIDTH'(1);
      GST_DIV4: mask = WIDTH'(3);
      GST_DIV8: mask = WIDTH'(7);
    endcase
  end

  assign inc = tick & ((cnt & mask) == mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clear) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= (inc) ? '0 : cnt + WIDTH'(1);
    end
  end
endmodule : gst_prescaler

// ==== hw/gst_timer.sv ====
// Purpose: Gated sixteen bit timer/counter with APB registers.
// Assumes: All pin inputs are synchronous to pclk; pclk is the oscillator.
// Notes:   Instruction clock is pclk divided by four as an enable pulse.
`timescale 1ns/1ps

module gst_timer (
  input  wire logic        pclk,                        // System clock.
  input  wire logic        presetn,                     // Asynchronous reset.
  input  wire logic        psel,                        // APB select.
  input  wire logic        penable,                     // APB enable.
  input  wire logic        pwrite,                      // APB direction.
  input  wire logic [7:0]  paddr,                       // APB byte address.
  input  wire logic [31:0] pwdata,                      // APB write data.
  output logic      [31:0] prdata,                      // APB read data.
  output logic             pready,                      // APB ready.
  output logic             pslverr,                     // APB error.
  input  wire logic        external_count_pin,          // External count input.
  input  wire logic        low_power_crystal_clock,     // Crystal clock level.
  input  wire logic        internal_osc_no_clkout_mode, // Core clock mode.
  input  wire logic        gate_pin,                    // Gate pin level.
  input  wire logic        second_comparator_output,    // Comparator gate.
  input  wire logic        core_sleep,                  // Core in Sleep.
  input  wire logic        special_event_trigger,       // Clear request pulse.
  input  wire logic        osc_pin_a_data,              // Shared pin A level.
  input  wire logic        osc_pin_b_data,              // Shared pin B level.
  output logic      [15:0] count_value,                 // Count to the unit.
  output logic             overflow_irq,                // Interrupt request.
  output logic             wake_request,                // Wake from Sleep.
  output logic             crystal_osc_run,             // Oscillator enable.
  output logic             osc_pin_a_direction,         // Pin A direction.
  output logic             osc_pin_b_direction          // Pin B direction.
);
  import gst_pkg::*;

  gst_ctrl_s   ctrl;
  logic [3:0]  irq_cfg;
  logic        overflow_flag;
  logic [1:0]  port_dir;
  logic [1:0]  instr_div;
  logic        counter_armed;
  logic        timer_on_q;

  // Bus decode.
  // Writes land only in the access phase, at the edge where pready is high.
  wire setup      = psel & ~penable;
  wire access     = psel & penable & pready;
  wire wr         = access & pwrite;
  wire hit_low    = paddr == GST_OFF_COUNT_LOW;
  wire hit_high   = paddr == GST_OFF_COUNT_HIGH;
  wire hit_ctrl   = paddr == GST_OFF_CONTROL;
  wire hit_irq    = paddr == GST_OFF_IRQ_CFG;
  wire hit_stat   = paddr == GST_OFF_STATUS;
  wire hit_port   = paddr == GST_OFF_PORT;
  wire mapped     = hit_low | hit_high | hit_ctrl | hit_irq | hit_stat | hit_port;
  wire wr_low     = wr & hit_low;
  wire wr_high    = wr & hit_high;
  wire wr_count   = wr_low | wr_high;
  wire wr_ctrl    = wr & hit_ctrl;
  wire wr_irq     = wr & hit_irq;
  wire wr_stat    = wr & hit_stat;
  wire wr_port    = wr & hit_port;

  // Control byte as written, so single fields can be looked at before they land.
  gst_ctrl_s wr_ctrl_val;
  assign wr_ctrl_val = gst_ctrl_s'(pwdata[7:0]);

  // Configuration fields.
  wire gate_source_select    = irq_cfg[GST_IRQ_GSS_BIT];
  wire overflow_irq_enable   = irq_cfg[GST_IRQ_IE_BIT];
  wire peripheral_irq_enable = irq_cfg[GST_IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
  wire global_irq_enable     = irq_cfg[GST_IRQ_GIE_BIT];

  // Instruction clock enable, one pulse every four pclk cycles.
  wire instr_tick = instr_div == GST_INSTR_DIV_LAST;

  wire use_crystal = ctrl.crystal_osc_enable & internal_osc_no_clkout_mode;
  wire ext_level   = use_crystal ? low_power_crystal_clock : external_count_pin;

  // Edge detection; bypass only counts in external mode.
  logic ext_rise;
  logic ext_fall;

  // two stage sync
  // Flipping the bypass bit swaps the edge path, so one edge may be lost or doubled.
  gst_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .bypass  (ctrl.sync_bypass),
    .din     (ext_level),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  wire gate_src    = gate_source_select ? second_comparator_output : gate_pin;
  wire gate_active = ctrl.gate_polarity ? gate_src : ~gate_src;
  wire gate_ok     = ~ctrl.gate_enable | gate_active;

  // only bypassed external counting runs in Sleep
  wire sleep_ok = ~core_sleep | (ctrl.clock_source_select & ctrl.sync_bypass);

  wire ext_tick = ext_rise & counter_armed;
  wire src_tick = ctrl.clock_source_select ? ext_tick : instr_tick;
  wire run      = ctrl.timer_on & gate_ok & sleep_ok;
  wire pre_tick = src_tick & run;

  logic inc;

  gst_prescaler #(
    .WIDTH (3)
  ) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (wr_count),
    .tick    (pre_tick),
    .sel     (ctrl.prescale_select),
    .inc     (inc)
  );

  wire rollover = inc & (count_value == GST_COUNT_ALL_ONES);

  // next count, write first
  // A byte write outranks the compare clear, so software always sees its own value.
  logic [15:0] next_count;
  always_comb begin
    next_count = count_value;
    if (wr_low) begin
      next_count[7:0] = pwdata[7:0];
    end else if (wr_high) begin
      next_count[15:8] = pwdata[7:0];
    end else if (special_event_trigger) begin
      next_count = 16'h0000;
    end else if (inc) begin
      next_count = count_value + 16'h0001;
    end
  end

  // write races with increments resolve by priority above.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= 16'h0000;
    end else begin
      count_value <= next_count;
    end
  end

  // Instruction clock divider; it runs free, so its phase is arbitrary.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // falling edge arms counter
  // Arming drops while timer_on is clear, when it sets and on a count write, so a restart waits for a new falling edge.
  wire enable_rise = ctrl.timer_on & ~timer_on_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_armed <= 1'b0;
      timer_on_q    <= 1'b0;
    end else begin
      timer_on_q <= ctrl.timer_on;
      if (wr_count | enable_rise | ~ctrl.timer_on) begin
        counter_armed <= 1'b0;
      end else if (ext_fall) begin
        counter_armed <= 1'b1;
      end
    end
  end

  // Control and configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= gst_ctrl_s'(GST_CONTROL_RESET);
    end else if (wr_ctrl) begin
      ctrl <= wr_ctrl_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_cfg <= GST_IRQ_CFG_RESET;
    end else if (wr_irq) begin
      irq_cfg <= pwdata[3:0];
    end
  end

  wire ovf_clear = wr_stat & ~pwdata[GST_STATUS_OVF_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (rollover) begin
      overflow_flag <= 1'b1;
    end else if (ovf_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  wire next_irq = overflow_flag & ctrl.timer_on & overflow_irq_enable &
                  peripheral_irq_enable & global_irq_enable;
  wire next_wake = overflow_flag & core_sleep & ctrl.timer_on &
                   overflow_irq_enable & peripheral_irq_enable &
                   ctrl.sync_bypass & ctrl.clock_source_select;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= next_irq;
    end
  end

  // Wake ignores the global enable: a masked core still resumes, it only skips the handler.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= next_wake;
    end
  end

  // oscillator enable output
  // Taken from the control write itself, so the run output moves on the same edge as the bit.
  wire next_ctrl_osc = wr_ctrl ? wr_ctrl_val.crystal_osc_enable : ctrl.crystal_osc_enable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_osc_run <= 1'b0;
    end else begin
      crystal_osc_run <= next_ctrl_osc;
    end
  end

  wire [1:0] next_port_dir = wr_port ? pwdata[1:0] : port_dir;
  wire [1:0] dir_view      = next_ctrl_osc ? 2'h3 : next_port_dir;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_dir <= GST_PORT_DIR_RESET;
    end else begin
      port_dir <= next_port_dir;
    end
  end

  // The pins see the forced view; the stored bits return once the crystal is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_pin_a_direction <= GST_PORT_DIR_RESET[0];
      osc_pin_b_direction <= GST_PORT_DIR_RESET[1];
    end else begin
      osc_pin_a_direction <= dir_view[0];
      osc_pin_b_direction <= dir_view[1];
    end
  end

  wire [1:0] dir_read  = ctrl.crystal_osc_enable ? 2'h3 : port_dir;
  wire [1:0] data_read = ctrl.crystal_osc_enable ? 2'h0
                         : {osc_pin_b_data, osc_pin_a_data};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_low) begin
      rd_mux[7:0] = count_value[7:0];
    end else if (hit_high) begin
      rd_mux[7:0] = count_value[15:8];
    end else if (hit_ctrl) begin
      rd_mux[7:0] = ctrl;
    end else if (hit_irq) begin
      rd_mux[3:0] = irq_cfg;
    end else if (hit_stat) begin
      rd_mux[GST_STATUS_OVF_BIT] = overflow_flag;
    end else if (hit_port) begin
      rd_mux[3:0] = {data_read, dir_read};
    end
  end

  // One wait-free access phase: the answer is prepared during setup.
  // Read data stays zero outside a read access, so stale values never leak.
  wire [31:0] next_prdata = (setup & ~pwrite) ? rd_mux : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // count_value feeds the capture/compare unit directly.
endmodule : gst_timer

// ==== tb/gst_timer_asserts.sv ====
// Purpose: Port checks of the gated sixteen bit timer.
// Assumes: Control and enable bytes are shadowed from APB writes.
// Notes:   Bound to every gst_timer instance.
`timescale 1ns/1ps
module gst_timer_asserts (
  input wire logic        pclk,                  // Clock.
  input wire logic        presetn,               // Reset.
  input wire logic        psel,                  // Select.
  input wire logic        penable,               // Enable.
  input wire logic        pwrite,                // Direction.
  input wire logic [7:0]  paddr,                 // Address.
  input wire logic [31:0] pwdata,                // Write data.
  input wire logic        pready,                // Ready.
  input wire logic        core_sleep,            // Sleep.
  input wire logic        special_event_trigger, // Clear.
  input wire logic [15:0] count_value,           // Count.
  input wire logic        overflow_irq,          // Request.
  input wire logic        wake_request,          // Wake.
  input wire logic        crystal_osc_run,       // Crystal.
  input wire logic        osc_pin_a_direction,   // Dir A.
  input wire logic        osc_pin_b_direction    // Dir B.
);
  import gst_pkg::*;
  logic       acc;
  logic       cwr;
  logic [7:0] ctl;
  logic [3:0] cfg;
  assign acc = psel && penable && pready && pwrite;
  assign cwr = acc && (paddr == GST_OFF_COUNT_LOW || paddr == GST_OFF_COUNT_HIGH);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= GST_CONTROL_RESET;
      cfg <= GST_IRQ_CFG_RESET;
    end else begin
      if (acc && paddr == GST_OFF_CONTROL) ctl <= pwdata[7:0];
      if (acc && paddr == GST_OFF_IRQ_CFG) cfg <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wrap_s;
    $past(count_value) == GST_COUNT_ALL_ONES && count_value == 16'h0000;
  endsequence
  sequence armed_s;
    ctl[0] && cfg[3:1] == 3'h7 && !$past(cwr) && !$past(special_event_trigger);
  endsequence
  ready_one_a:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("bad pready");
  low_write_a:
    assert property (cwr && paddr == GST_OFF_COUNT_LOW |=> count_value[7:0] == $past(pwdata[7:0])) else $error("bad low");
  high_write_a:
    assert property (cwr && paddr == GST_OFF_COUNT_HIGH |=> count_value[15:8] == $past(pwdata[7:0])) else $error("bad high");
  stop_hold_a:
    assert property ((!ctl[0] && !cwr && !special_event_trigger) [*4] |=> $stable(count_value)) else $error("stopped moved");
  event_clear_a:
    assert property (special_event_trigger && !cwr |=> count_value == 16'h0000) else $error("no clear");
  wrap_flag_a:
    assert property (wrap_s ##0 armed_s |=> overflow_irq) else $error("no flag");
  irq_cause_a:
    assert property (overflow_irq |-> $past(ctl[0] && cfg[3:1] == 3'h7)) else $error("bad irq");
  wake_cause_a:
    assert property (wake_request |-> $past(core_sleep && ctl[2:0] == 3'h7 && cfg[2:1] == 2'h3)) else $error("bad wake");
  crystal_run_a:
    assert property (crystal_osc_run == ctl[3]) else $error("bad crystal");
  dir_force_a:
    assert property (ctl[3] && $past(ctl[3]) |-> osc_pin_a_direction && osc_pin_b_direction) else $error("bad dir");
endmodule : gst_timer_asserts
bind gst_timer gst_timer_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .core_sleep(core_sleep),
  .special_event_trigger(special_event_trigger), .count_value(count_value), .overflow_irq(overflow_irq),
  .wake_request(wake_request), .crystal_osc_run(crystal_osc_run),
  .osc_pin_a_direction(osc_pin_a_direction), .osc_pin_b_direction(osc_pin_b_direction));

// ==== tb/gst_partner.sv ====
// Purpose: External count clock, crystal and compare unit model.
// Assumes: Clocks stand still low between bursts.
// Notes:   Period zero turns the compare event off.
`timescale 1ns/1ps
module gst_partner (
  input  wire logic        pclk,        // Clock.
  input  wire logic [15:0] count_value, // Count.
  input  wire logic [15:0] period,      // Compare pair.
  output logic             ext_clk,     // Count pin.
  output logic             xtal_clk,    // Crystal.
  output logic             sevt         // Clear pulse.
);
  initial begin
    ext_clk = 1'b0;
    xtal_clk = 1'b0;
  end
  assign sevt = period != 16'h0000 && count_value == period;
  task automatic burst(input int n, input int half, input logic x);
    repeat (n) begin
      repeat (half) @(posedge pclk);
      if (x) xtal_clk <= 1'b1; else ext_clk <= 1'b1;
      repeat (half) @(posedge pclk);
      if (x) xtal_clk <= 1'b0; else ext_clk <= 1'b0;
    end
  endtask : burst
endmodule : gst_partner

// ==== tb/gst_timer_tb.sv ====
// Purpose: Self-checking bench of the gated sixteen bit timer.
// Assumes: Register traffic waits for pready.
// Notes:   Free-running counts allow one count of phase slack.
`timescale 1ns/1ps
module gst_timer_tb;
  import gst_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        mode_io, gate_pin, cmp, sleep, tb_sevt, ext, xtal, p_sevt;
  logic        irq, wake, xrun, dir_a, dir_b;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cnt, period, cv;
  int          miscompares = 0;
  int          checks_done = 0;
  int          seed = 13;
  int          mdl;
  gst_partner prt (.pclk(pclk), .count_value(cnt), .period(period), .ext_clk(ext), .xtal_clk(xtal), .sevt(p_sevt));
  gst_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(ext), .low_power_crystal_clock(xtal), .internal_osc_no_clkout_mode(mode_io),
    .gate_pin(gate_pin), .second_comparator_output(cmp), .core_sleep(sleep),
    .special_event_trigger(p_sevt | tb_sevt), .osc_pin_a_data(1'b1), .osc_pin_b_data(1'b1),
    .count_value(cnt), .overflow_irq(irq), .wake_request(wake), .crystal_osc_run(xrun),
    .osc_pin_a_direction(dir_a), .osc_pin_b_direction(dir_b));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] e);
    return (s === e || s === e + 1 || s + 1 === e) ? e : s;
  endfunction : near
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk
  task automatic wcnt(input logic [15:0] v);
    apb(1'b1, GST_OFF_COUNT_LOW, {24'h0, v[7:0]});
    apb(1'b1, GST_OFF_COUNT_HIGH, {24'h0, v[15:8]});
  endtask : wcnt
  task automatic rcnt();
    apb(1'b0, GST_OFF_COUNT_HIGH, 32'h0);
    cv[15:8] = rd[7:0];
    apb(1'b0, GST_OFF_COUNT_LOW, 32'h0);
    cv[7:0] = rd[7:0];
  endtask : rcnt
  task automatic run(input logic [7:0] c, input int n);
    apb(1'b1, GST_OFF_CONTROL, {24'h0, c});
    repeat (n) @(posedge pclk);
    apb(1'b1, GST_OFF_CONTROL, {24'h0, c & 8'hfe});
  endtask : run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mode_io, gate_pin, cmp, sleep, tb_sevt} = '0;
    period = 16'h0000;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(GST_OFF_CONTROL, 32'h0);
    rchk(GST_OFF_PORT, 32'hf);
    apb(1'b1, 8'h18, 32'hff);
    check(err, 1'b1);
    repeat (3) begin
      mdl = $random(seed) & 32'hffff;
      wcnt(mdl[15:0]);
      rcnt();
      check(cv, mdl);
    end
    for (int d = 0; d < 4; d++) begin
      wcnt(16'h0);
      run({2'b00, d[1:0], 4'h1}, 64 << d);
      rcnt();
      check(near(cv, 16), 16);
    end
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, GST_OFF_CONTROL, 32'h0);
      wcnt(16'h0);
      apb(1'b1, GST_OFF_CONTROL, {29'h0, b[0], 2'b11});
      prt.burst(5, 1 + 3 * b, 1'b0);
      prt.burst(2, 2, 1'b1);
      rcnt();
      check(cv, 16'h4);
    end
    mode_io <= 1'b1;
    apb(1'b1, GST_OFF_CONTROL, 32'h0a);
    repeat (16) @(posedge pclk);
    wcnt(16'h0);
    apb(1'b1, GST_OFF_CONTROL, 32'h0b);
    prt.burst(3, 2, 1'b0);
    prt.burst(4, 2, 1'b1);
    rchk(GST_OFF_PORT, 32'h3);
    check({xrun, dir_a, dir_b}, 3'h7);
    rcnt();
    check(cv, 16'h3);
    mode_io <= 1'b0;
    apb(1'b1, GST_OFF_CONTROL, 32'h0);
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, GST_OFF_IRQ_CFG, g >> 1);
      gate_pin <= g[1] ? g[0] : !g[0];
      cmp <= g[1] ? !g[0] : g[0];
      wcnt(16'h0);
      run({g[0], 7'h41}, 64);
      rcnt();
      check(cv, 16'h0);
      gate_pin <= !gate_pin;
      cmp <= !cmp;
      wcnt(16'h0);
      run({g[0], 7'h41}, 64);
      rcnt();
      check(near(cv, 16), 16);
    end
    sleep <= 1'b1;
    wcnt(16'h0);
    run(8'h01, 64);
    rcnt();
    check(cv, 16'h0);
    apb(1'b1, GST_OFF_IRQ_CFG, 32'he);
    wcnt(16'hfffe);
    apb(1'b1, GST_OFF_CONTROL, 32'h07);
    prt.burst(4, 1, 1'b0);
    repeat (4) @(posedge pclk);
    check({irq, wake}, 2'h3);
    apb(1'b1, GST_OFF_IRQ_CFG, 32'h6);
    repeat (2) @(posedge pclk);
    check({irq, wake}, 2'h1);
    rchk(GST_OFF_STATUS, 32'h1);
    apb(1'b1, GST_OFF_STATUS, 32'h0);
    rchk(GST_OFF_STATUS, 32'h0);
    rcnt();
    check(cv, 16'h1);
    sleep <= 1'b0;
    period <= 16'hfff8;
    apb(1'b1, GST_OFF_CONTROL, 32'h0);
    wcnt(16'hfff0);
    run(8'h01, 200);
    period <= 16'h0;
    rcnt();
    check(cv < 16'h40, 1'b1);
    rchk(GST_OFF_STATUS, 32'h0);
    tb_sevt <= 1'b1;
    apb(1'b1, GST_OFF_COUNT_LOW, 32'h5a);
    tb_sevt <= 1'b0;
    rcnt();
    check(cv[7:0], 8'h5a);
    print_verdict();
  end
endmodule : gst_timer_tb
